//--- shared/hbsc_pkg.sv
// constants and types for the halt and bus stall controller
package hbsc_pkg;
    localparam int HBSC_PMODE_W = 2;
    localparam logic [1:0] HBSC_PMODE_SINGLE = 2'h0;
    localparam logic [1:0] HBSC_PMODE_MEMEXP = 2'h1;
    localparam logic [1:0] HBSC_PMODE_MICRO = 2'h2;
    localparam int HBSC_WAIT_BIT = 2;
    localparam logic [7:0] HBSC_PMR_RESET = 8'h00;
    localparam logic [11:0] HBSC_WDT_PRELOAD = 12'hfff;
    localparam int HBSC_WDT_W = 12;
    localparam int HBSC_DIV32 = 32;
    localparam int HBSC_DIV512 = 512;
    localparam logic [1:0] HBSC_NOWAIT_LOW = 2'h1;
    localparam logic [1:0] HBSC_ONEWAIT_LOW = 2'h2;
    localparam int HBSC_PORT_W = 8;

    typedef enum logic [4:0] {
        HBSC_RUN = 5'h01,
        HBSC_STOP = 5'h02,
        HBSC_WAIT = 5'h04,
        HBSC_READY = 5'h08,
        HBSC_HOLD = 5'h10
    } hbsc_state_e;
endpackage : hbsc_pkg

//--- hdl/hbsc_sync.sv
// two-flop synchroniser for pin inputs, vector wide
`timescale 1ns/1ps
module hbsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            q_o <= INIT;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : hbsc_sync

//--- hdl/hbsc_top.sv
// halt, wait, one-wait, ready and hold control of the processor bus
`timescale 1ns/1ps
// Function
// - stop and wait accepted in every mode
// - strobe frozen during stop, wait, ready
// - wait bit zero gives one-wait externally
// - one-wait doubles strobe low phase
// - wait bit one removes extra wait
// - ready low during an external access freezes bus and ports
// - hold floats P0, P1, P2, P30, P31
// - hold drives P32, P33 low
// - hold keeps P43-P47, P5-P8 unchanged
// - stop halts watchdog, preloads fff, div32
// - wait bit zero adds wait per access
// - reset ending stop/wait keeps RAM; here reset clears ram_keep_o
// - pins, ext-clock serial, event timers wake stop
module hbsc_top
    import hbsc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic stop_instruction_i,
    input wire logic wait_instruction_i,
    input wire logic [1:0] pmode_i,
    input wire logic wait_bit_i,
    input wire logic ext_access_i,
    input wire logic ext_irq_pin_i,
    input wire logic ext_serial_irq_i,
    input wire logic event_timer_irq_i,
    input wire logic any_irq_i,
    input wire logic ready_n_i,
    input wire logic hold_n_i,
    input wire logic [7:0] p0_i,
    input wire logic [7:0] p1_i,
    input wire logic [7:0] p2_i,
    input wire logic [7:0] p3_i,
    input wire logic [7:0] p4_i,
    input wire logic [7:0] p5_i,
    input wire logic [7:0] p6_i,
    input wire logic [7:0] p7_i,
    input wire logic [7:0] p8_i,
    input wire logic [7:0] p0_oe_i,
    input wire logic [7:0] p1_oe_i,
    input wire logic [7:0] p2_oe_i,
    input wire logic [7:0] p3_oe_i,
    output logic [7:0] p0_o,
    output logic [7:0] p1_o,
    output logic [7:0] p2_o,
    output logic [7:0] p3_o,
    output logic [7:0] p4_o,
    output logic [7:0] p5_o,
    output logic [7:0] p6_o,
    output logic [7:0] p7_o,
    output logic [7:0] p8_o,
    output logic [7:0] p0_oe_o,
    output logic [7:0] p1_oe_o,
    output logic [7:0] p2_oe_o,
    output logic [7:0] p3_oe_o,
    output logic strobe_o,
    output logic strobe_done_o,
    output logic osc_run_o,
    output logic clk_out_o,
    output logic cpu_stall_o,
    output logic hold_ack_o,
    output logic wdt_run_o,
    output logic wdt_div32_o,
    output logic [11:0] wdt_preload_o,
    output logic wdt_load_o,
    output logic ram_keep_o,
    output logic [4:0] state_o
);
    // =====================================================
    // pin synchronisers
    logic ready_n_s;
    logic hold_n_s;
    logic [1:0] pins_s;
    hbsc_sync #(.W(2), .INIT(2'h3)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({ready_n_i, hold_n_i}),
        .q_o(pins_s)
    );
    assign ready_n_s = pins_s[1];
    assign hold_n_s = pins_s[0];

    // =====================================================
    // state
    typedef struct packed {
        hbsc_state_e st;
        logic strobe;
        logic [1:0] lowcnt;
        logic in_access;
        logic clk_out;
        logic wdt_div32;
        logic wdt_load;
        logic ram_keep;
        logic [8:0][7:0] port;
        logic [3:0][7:0] oe;
    } hbsc_reg_s;

    hbsc_reg_s s_r;
    hbsc_reg_s s_nxt;

    function automatic logic expansion(input logic [1:0] m);
        expansion = (m == HBSC_PMODE_MEMEXP) || (m == HBSC_PMODE_MICRO);
    endfunction : expansion

    logic stop_wake;
    logic [8:0][7:0] port_in;
    logic [3:0][7:0] oe_in;
    logic [1:0] low_len;

    assign port_in = {p8_i, p7_i, p6_i, p5_i, p4_i, p3_i, p2_i, p1_i, p0_i};
    assign oe_in = {p3_oe_i, p2_oe_i, p1_oe_i, p0_oe_i};
    assign stop_wake = ext_irq_pin_i | ext_serial_irq_i | event_timer_irq_i;
    // wait bit clear doubles low phase on external accesses
    assign low_len = wait_bit_i ? HBSC_NOWAIT_LOW : HBSC_ONEWAIT_LOW;

    always_comb begin
        s_nxt = s_r;
        s_nxt.wdt_load = 1'b0;
        s_nxt.clk_out = ~s_r.clk_out;
        case (s_r.st)
            HBSC_RUN: begin
                s_nxt.port = port_in;
                s_nxt.oe = oe_in;
                if (s_r.in_access) begin
                    if (s_r.lowcnt >= low_len) begin
                        s_nxt.in_access = 1'b0;
                        s_nxt.strobe = 1'b1;
                        s_nxt.lowcnt = 2'h0;
                    end else begin
                        s_nxt.lowcnt = s_r.lowcnt + 2'h1;
                    end
                end else if (ext_access_i) begin
                    s_nxt.in_access = 1'b1;
                    s_nxt.strobe = 1'b0;
                    s_nxt.lowcnt = 2'h1;
                end
                // ready is sampled only mid-access so an idle low line is harmless
                if (stop_instruction_i) begin
                    s_nxt.st = HBSC_STOP;
                    s_nxt.port = s_r.port;
                    s_nxt.strobe = s_r.strobe;
                    s_nxt.in_access = s_r.in_access;
                    s_nxt.lowcnt = s_r.lowcnt;
                    s_nxt.oe = s_r.oe;
                    s_nxt.clk_out = 1'b0;
                    s_nxt.wdt_div32 = 1'b1;
                    s_nxt.wdt_load = 1'b1;
                    s_nxt.ram_keep = 1'b1;
                end else if (wait_instruction_i) begin
                    s_nxt.st = HBSC_WAIT;
                    s_nxt.oe = s_r.oe;
                    s_nxt.port = s_r.port;
                    s_nxt.strobe = s_r.strobe;
                    s_nxt.in_access = s_r.in_access;
                    s_nxt.lowcnt = s_r.lowcnt;
                    s_nxt.ram_keep = 1'b1;
                end else if (s_r.in_access && !ready_n_s) begin
                    s_nxt.st = HBSC_READY;
                    s_nxt.port = s_r.port;
                    s_nxt.oe = s_r.oe;
                    s_nxt.strobe = s_r.strobe;
                    s_nxt.in_access = s_r.in_access;
                    s_nxt.lowcnt = s_r.lowcnt;
                end else if (!hold_n_s && expansion(pmode_i) && !s_r.in_access) begin
                    s_nxt.st = HBSC_HOLD;
                    s_nxt.strobe = 1'b1;
                    s_nxt.port = s_r.port;
                end
            end
            HBSC_STOP: begin
                s_nxt.clk_out = 1'b0;
                if (stop_wake) begin
                    s_nxt.st = HBSC_RUN;
                    s_nxt.ram_keep = 1'b0;
                end
            end
            HBSC_WAIT: begin
                if (any_irq_i || stop_wake) begin
                    s_nxt.st = HBSC_RUN;
                    s_nxt.ram_keep = 1'b0;
                end
            end
            HBSC_READY: begin
                if (ready_n_s) begin
                    s_nxt.st = HBSC_RUN;
                end
            end
            HBSC_HOLD: begin
                if (hold_n_s) begin
                    s_nxt.st = HBSC_RUN;
                end
            end
            default: begin
                s_nxt.st = HBSC_RUN;
            end
        endcase
    end

    // ram_keep is cleared by reset, so the system must latch it before reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '{st: HBSC_RUN, strobe: 1'b1, lowcnt: 2'h0, in_access: 1'b0,
                     clk_out: 1'b0, wdt_div32: 1'b0, wdt_load: 1'b0, ram_keep: 1'b0,
                     port: '0, oe: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // =====================================================
    // outputs
    logic holding;
    assign holding = (s_r.st == HBSC_HOLD);
    assign p0_o = s_r.port[0];
    assign p1_o = s_r.port[1];
    assign p2_o = s_r.port[2];
    assign p3_o = holding ? {s_r.port[3][7:4], 4'h0} : s_r.port[3];
    assign p4_o = s_r.port[4];
    assign p5_o = s_r.port[5];
    assign p6_o = s_r.port[6];
    assign p7_o = s_r.port[7];
    assign p8_o = s_r.port[8];
    assign p0_oe_o = holding ? 8'h00 : s_r.oe[0];
    assign p1_oe_o = holding ? 8'h00 : s_r.oe[1];
    assign p2_oe_o = holding ? 8'h00 : s_r.oe[2];
    assign p3_oe_o = holding ? {s_r.oe[3][7:4], 4'hc} : s_r.oe[3];
    assign strobe_o = s_r.strobe;
    assign strobe_done_o = s_r.in_access && (s_r.st == HBSC_RUN) && (s_r.lowcnt >= low_len);
    assign osc_run_o = (s_r.st != HBSC_STOP);
    assign clk_out_o = s_r.clk_out;
    assign cpu_stall_o = (s_r.st != HBSC_RUN);
    assign hold_ack_o = holding;
    assign wdt_run_o = !(s_r.st == HBSC_STOP || holding);
    assign wdt_div32_o = s_r.wdt_div32;
    assign wdt_preload_o = HBSC_WDT_PRELOAD;
    assign wdt_load_o = s_r.wdt_load;
    assign ram_keep_o = s_r.ram_keep;
    assign state_o = s_r.st;
endmodule : hbsc_top

//--- tb/hbsc_far_end.sv
// far-side memory and bus master model driving ready and hold
`timescale 1ns/1ps
module hbsc_far_end (
    input wire logic sys_clk_i,
    input wire logic stall_i,
    input wire logic hold_req_i,
    output logic ready_n_o,
    output logic hold_n_o
);
    // ==========
    // pins
    // pulled up, so idle level is high
    initial begin
        ready_n_o = 1'b1;
        hold_n_o = 1'b1;
    end
    always @(posedge sys_clk_i) begin
        ready_n_o <= ~stall_i;
        hold_n_o <= ~hold_req_i;
    end
endmodule : hbsc_far_end

//--- tb/hbsc_top_asserts.sv
// port checker for the halt and bus stall controller
`timescale 1ns/1ps
module hbsc_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [4:0] state_o,
    input wire logic strobe_o,
    input wire logic osc_run_o,
    input wire logic clk_out_o,
    input wire logic hold_ack_o,
    input wire logic [7:0] p0_oe_o,
    input wire logic [7:0] p1_oe_o,
    input wire logic [7:0] p2_oe_o,
    input wire logic [7:0] p3_oe_o,
    input wire logic [7:0] p3_o,
    input wire logic [7:0] p5_o,
    input wire logic wdt_run_o,
    input wire logic wdt_div32_o,
    input wire logic wdt_load_o,
    input wire logic [1:0] pmode_i
);
    // ==========
    // properties
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_frz;
        state_o inside {5'h02, 5'h04, 5'h08} && $stable(state_o) |-> $stable(strobe_o);
    endproperty
    a_frz: assert property (p_frz) else $error("strobe moved");
    property p_osc; state_o == 5'h02 |-> !osc_run_o && !clk_out_o; endproperty
    a_osc: assert property (p_osc) else $error("clock runs in stop");
    property p_wdt; state_o == 5'h02 && $stable(state_o) |-> !wdt_run_o && wdt_div32_o; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog in stop");
    property p_ld; $rose(state_o == 5'h02) |-> ##[0:1] wdt_load_o; endproperty
    a_ld: assert property (p_ld) else $error("no preload");
    property p_flt;
        hold_ack_o |-> (p0_oe_o | p1_oe_o | p2_oe_o) == 8'h00 && p3_oe_o[1:0] == 2'h0;
    endproperty
    a_flt: assert property (p_flt) else $error("bus driven in hold");
    property p_low; hold_ack_o |-> p3_o[3:2] == 2'h0 && p3_oe_o[3:2] == 2'h3; endproperty
    a_low: assert property (p_low) else $error("hold pins not low");
    property p_keep; hold_ack_o && $past(hold_ack_o) |-> $stable(p5_o); endproperty
    a_keep: assert property (p_keep) else $error("port moved in hold");
    property p_hm; hold_ack_o |-> pmode_i != 2'h0 && !wdt_run_o && strobe_o; endproperty
    a_hm: assert property (p_hm) else $error("bad hold");
    c_stop: cover property (state_o == 5'h02);
    c_rdy: cover property (state_o == 5'h08);
    c_hold: cover property (hold_ack_o);
    c_wait: cover property (state_o == 5'h04);
endmodule : hbsc_chk
bind hbsc_top hbsc_chk u_chk (.*);

//--- tb/hbsc_top_tb.sv
// self-checking bench for the halt and bus stall controller
`timescale 1ns/1ps
module hbsc_top_tb import hbsc_pkg::*; ;
    logic sys_clk_i, rst_i, stop_instruction_i, wait_instruction_i, wait_bit_i, ext_access_i;
    logic ext_irq_pin_i, ext_serial_irq_i, event_timer_irq_i, any_irq_i, stall, hreq;
    logic [1:0] pmode_i;
    logic [7:0] cv, p0_oe_i, p1_oe_i, p2_oe_i, p3_oe_i;
    wire [7:0] p0_i = cv, p1_i = cv, p2_i = cv, p3_i = cv, p4_i = cv;
    wire [7:0] p5_i = cv, p6_i = cv, p7_i = cv, p8_i = cv;
    wire ready_n_i, hold_n_i;
    logic [7:0] p0_o, p1_o, p2_o, p3_o, p4_o, p5_o, p6_o, p7_o, p8_o;
    logic [7:0] p0_oe_o, p1_oe_o, p2_oe_o, p3_oe_o;
    logic strobe_o, strobe_done_o, osc_run_o, clk_out_o, cpu_stall_o, hold_ack_o;
    logic wdt_run_o, wdt_div32_o, wdt_load_o, ram_keep_o;
    logic [11:0] wdt_preload_o;
    logic [4:0] state_o;
    int error_cnt = 0;
    int total_checks = 0;
    hbsc_top uut (.*);
    hbsc_far_end far (.sys_clk_i, .stall_i(stall), .hold_req_i(hreq),
        .ready_n_o(ready_n_i), .hold_n_o(hold_n_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // ==========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : cyc
    // bounded wait; a hang ends the run
    task automatic wst(input logic [4:0] s);
        for (int i = 0; i < 20 && state_o !== s; i++) @(negedge sys_clk_i);
        chk(state_o, s);
        if (state_o !== s) give_verdict();
    endtask : wst
    task automatic acc(input logic wb, output int n);
        logic dn;
        dn = 1'b0;
        @(posedge sys_clk_i);
        wait_bit_i <= wb;
        ext_access_i <= 1'b1;
        @(posedge sys_clk_i);
        ext_access_i <= 1'b0;
        @(negedge sys_clk_i);
        for (n = 0; n < 9 && strobe_o !== 1'b1; n++) begin
            dn = strobe_done_o;
            @(negedge sys_clk_i);
        end
        chk(dn, 1'b1);
        if (n == 9) begin
            error_cnt++;
            give_verdict();
        end
    endtask : acc
    // ==========
    // scenarios
    task automatic t_onewait;
        int n1, n0, n2;
        acc(1'b1, n1);
        chk(n1, HBSC_NOWAIT_LOW);
        acc(1'b0, n0);
        chk(n0, 2 * n1);
        acc(1'b1, n2);
        chk(n2, n1);
    endtask : t_onewait
    task automatic t_stop;
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk_i);
            pmode_i <= 2'(m);
            stop_instruction_i <= 1'b1;
            @(posedge sys_clk_i);
            stop_instruction_i <= 1'b0;
            any_irq_i <= 1'b1;
            wst(5'h02);
            cyc(2);
            chk(state_o, 5'h02);
            chk({osc_run_o, wdt_run_o, wdt_div32_o, ram_keep_o}, 4'h3);
            chk(wdt_preload_o, 12'hfff);
            chk({clk_out_o, cpu_stall_o}, 2'h1);
            @(posedge sys_clk_i);
            any_irq_i <= 1'b0;
            {ext_irq_pin_i, ext_serial_irq_i, event_timer_irq_i} <= 3'h4 >> m;
            @(posedge sys_clk_i);
            {ext_irq_pin_i, ext_serial_irq_i, event_timer_irq_i} <= 3'h0;
            wst(5'h01);
        end
    endtask : t_stop
    task automatic t_wait;
        logic c;
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk_i);
            pmode_i <= 2'(m);
            wait_instruction_i <= 1'b1;
            @(posedge sys_clk_i);
            wait_instruction_i <= 1'b0;
            wst(5'h04);
            cyc(2);
            chk({osc_run_o, wdt_run_o, ram_keep_o}, 3'h7);
            c = clk_out_o;
            cyc(1);
            chk(clk_out_o, !c);
            @(posedge sys_clk_i);
            any_irq_i <= 1'b1;
            @(posedge sys_clk_i);
            any_irq_i <= 1'b0;
            wst(5'h01);
        end
    endtask : t_wait
    task automatic t_ready;
        @(posedge sys_clk_i);
        stall <= 1'b1;
        cyc(4);
        chk(state_o, 5'h01);
        @(posedge sys_clk_i);
        ext_access_i <= 1'b1;
        @(posedge sys_clk_i);
        ext_access_i <= 1'b0;
        wst(5'h08);
        @(posedge sys_clk_i);
        cv <= 8'h5a;
        cyc(3);
        chk({strobe_o, p5_o}, 9'h03c);
        @(posedge sys_clk_i);
        stall <= 1'b0;
        wst(5'h01);
        cyc(4);
        chk({strobe_o, p5_o}, 9'h15a);
    endtask : t_ready
    task automatic t_hold;
        @(posedge sys_clk_i);
        pmode_i <= 2'h0;
        hreq <= 1'b1;
        cyc(5);
        chk(hold_ack_o, 1'b0);
        @(posedge sys_clk_i);
        pmode_i <= 2'h1;
        wst(5'h10);
        @(posedge sys_clk_i);
        cv <= 8'ha5;
        cyc(2);
        chk({p0_oe_o, p1_oe_o, p2_oe_o, p3_oe_o[1:0]}, 26'h0);
        chk({p3_o[3:2], p3_oe_o[3:2], p5_o, strobe_o}, {4'h3, 8'h5a, 1'b1});
        @(posedge sys_clk_i);
        hreq <= 1'b0;
        wst(5'h01);
        cyc(3);
        chk({p0_oe_o, p5_o}, 16'hffa5);
    endtask : t_hold
    // reset in mid-run ends wait mode
    task automatic t_reset;
        @(posedge sys_clk_i);
        wait_instruction_i <= 1'b1;
        @(posedge sys_clk_i);
        wait_instruction_i <= 1'b0;
        wst(5'h04);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        cyc(2);
        chk({state_o, strobe_o, ram_keep_o}, {5'h01, 2'h2});
    endtask : t_reset
    initial begin
        rst_i = 1'b1;
        {stop_instruction_i, wait_instruction_i, ext_access_i, stall, hreq} = '0;
        {ext_irq_pin_i, ext_serial_irq_i, event_timer_irq_i, any_irq_i} = '0;
        {wait_bit_i, pmode_i, cv} = {1'b1, 2'h0, 8'h3c};
        {p0_oe_i, p1_oe_i, p2_oe_i, p3_oe_i} = '1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        cyc(3);
        t_onewait();
        t_stop();
        t_wait();
        t_ready();
        t_hold();
        t_reset();
        give_verdict();
    end
endmodule : hbsc_top_tb
